// File: iptc_defs.vh
`ifndef IPTC_DEFS_VH
`define IPTC_DEFS_VH

// register byte addresses
`define IPTC_ADR_STATUS      8'h00
`define IPTC_ADR_CORE        8'h04
`define IPTC_ADR_TRAP        8'h08
`define IPTC_ADR_VECEDGE     8'h0C
`define IPTC_ADR_FLAGS0      8'h10

// cpu_status_word fields
`define IPTC_PRIO_LO_MSB     7
`define IPTC_PRIO_LO_LSB     5

// core_control_word fields
`define IPTC_PRIO_UP_BIT     3

// interrupt_control_trap_flags fields
`define IPTC_NEST_DIS_BIT    15
`define IPTC_OVF_A_BIT       14
`define IPTC_OVF_B_BIT       13
`define IPTC_CAT_A_BIT       12
`define IPTC_CAT_B_BIT       11
`define IPTC_OVF_A_EN_BIT    10
`define IPTC_OVF_B_EN_BIT    9
`define IPTC_CAT_EN_BIT      8
`define IPTC_SHIFT_BIT       7
`define IPTC_DIV0_BIT        6
`define IPTC_DMA_BIT         5
`define IPTC_MATH_BIT        4
`define IPTC_ADDR_BIT        3
`define IPTC_STACK_BIT       2
`define IPTC_OSC_BIT         1
`define IPTC_TRAP_RW_MASK    16'hFFFE

// interrupt_control_vector_edge fields
`define IPTC_ALT_VEC_BIT     15
`define IPTC_DISABLE_INSTRUCTION_ACTIVE_BIT        14
`define IPTC_EDGE_MSB        4

// interrupt_flag_status_zero fields
`define IPTC_EXT0_FLAG_BIT   0
`define IPTC_DMA1_FLAG_BIT   14
`define IPTC_FLAGS0_MASK     16'h7FFF

// reset values
`define IPTC_RST_PRIO_LO     3'h0
`define IPTC_RST_PRIO_UP     1'h0
`define IPTC_RST_TRAP        16'h0000
`define IPTC_RST_ALT_VEC     1'h0
`define IPTC_RST_EDGE        5'h00
`define IPTC_RST_FLAGS0      16'h0000

`endif

// File: iptc_interrupt_priority_trap_control.v
// Our own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "iptc_defs.vh"

module iptc_interrupt_priority_trap_control (
   // clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // wishbone slave
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [7:0]  adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output reg  [31:0] dat_o,
   output wire        ack_o,
   // cpu core
   input  wire        cpu_level_load_i,
   input  wire [3:0]  cpu_level_i,
   input  wire        disable_instruction_active_i,
   output wire [3:0]  prio_level_o,
   output wire        user_irq_block_o,
   output wire        nesting_disable_o,
   output wire        alternate_vector_select_o,
   // trap sources, one-cycle pulses
   input  wire        acc_a_overflow_i,
   input  wire        acc_b_overflow_i,
   input  wire        acc_a_catastrophic_i,
   input  wire        acc_b_catastrophic_i,
   input  wire        bad_shift_i,
   input  wire        divide_zero_i,
   input  wire        math_fault_i,
   input  wire        dma_fault_i,
   input  wire        address_fault_i,
   input  wire        stack_fault_i,
   input  wire        osc_failure_i,
   output wire        trap_event_o,
   // interrupt sources
   input  wire [4:0]  ext_irq_i,
   input  wire [14:1] periph_req_i,
   output wire [4:0]  ext_edge_o,
   output wire [15:0] request_flags_o
);

   reg  [2:0]  priority_low_field_r;
   reg  [2:0]  priority_low_field_nxt;
   reg         priority_upper_bit_r;
   reg         priority_upper_bit_nxt;
   reg         alternate_vector_select_r;
   reg         alternate_vector_select_nxt;
   reg  [4:0]  edge_polarity_r;
   reg  [4:0]  edge_polarity_nxt;
   reg         ack_r;
   reg  [15:0] trap_set;
   reg  [15:0] rd_word;

   wire [15:0] trap_flags_r;
   wire [15:0] flag_status_zero_r;
   wire [15:0] flag_set;
   wire        bus_req;
   wire        wr_stb;
   wire [15:0] wmask;
   wire [15:0] wdata;
   wire        wr_status;
   wire        wr_trap;
   wire        wr_vecedge;
   wire        wr_flags0;
   wire        math_any;

   // wishbone classic: one wait state, ack drops after one cycle
   assign bus_req = cyc_i & stb_i;
   assign ack_o   = ack_r;
   assign wr_stb  = bus_req & we_i & ~ack_r;
   assign wmask   = {{8{sel_i[1]}}, {8{sel_i[0]}}};
   assign wdata   = dat_i[15:0];

   assign wr_status  = wr_stb & (adr_i == `IPTC_ADR_STATUS);
   assign wr_trap    = wr_stb & (adr_i == `IPTC_ADR_TRAP);
   assign wr_vecedge = wr_stb & (adr_i == `IPTC_ADR_VECEDGE);
   assign wr_flags0  = wr_stb & (adr_i == `IPTC_ADR_FLAGS0);

   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= bus_req & ~ack_r;
      end
   end

   // effective priority level and blocking
   assign prio_level_o     = {priority_upper_bit_r, priority_low_field_r};
   assign user_irq_block_o = priority_upper_bit_r;
   assign nesting_disable_o = trap_flags_r[`IPTC_NEST_DIS_BIT];
   assign alternate_vector_select_o = alternate_vector_select_r;

   // low priority field: software write unless nesting disabled
   always @* begin
      priority_low_field_nxt = priority_low_field_r;
      if (wr_status & sel_i[0] & ~trap_flags_r[`IPTC_NEST_DIS_BIT]) begin
         priority_low_field_nxt = wdata[`IPTC_PRIO_LO_MSB:`IPTC_PRIO_LO_LSB];
      end
      if (cpu_level_load_i) begin
         priority_low_field_nxt = cpu_level_i[2:0];
      end
   end

   // upper bit: only the core loads it, level above seven
   always @* begin
      priority_upper_bit_nxt = priority_upper_bit_r;
      if (cpu_level_load_i) begin
         priority_upper_bit_nxt = cpu_level_i[3];
      end
   end

   // trap flag setting, overflow and catastrophic flags gated by enables
   assign math_any = bad_shift_i | divide_zero_i | math_fault_i;

   always @* begin
      trap_set = 16'h0000;
      trap_set[`IPTC_OVF_A_BIT] = acc_a_overflow_i
                                & trap_flags_r[`IPTC_OVF_A_EN_BIT];
      trap_set[`IPTC_OVF_B_BIT] = acc_b_overflow_i
                                & trap_flags_r[`IPTC_OVF_B_EN_BIT];
      trap_set[`IPTC_CAT_A_BIT] = acc_a_catastrophic_i
                                & trap_flags_r[`IPTC_CAT_EN_BIT];
      trap_set[`IPTC_CAT_B_BIT] = acc_b_catastrophic_i
                                & trap_flags_r[`IPTC_CAT_EN_BIT];
      trap_set[`IPTC_SHIFT_BIT] = bad_shift_i;
      trap_set[`IPTC_DIV0_BIT]  = divide_zero_i;
      trap_set[`IPTC_DMA_BIT]   = dma_fault_i;
      trap_set[`IPTC_MATH_BIT]  = math_any;
      trap_set[`IPTC_ADDR_BIT]  = address_fault_i;
      trap_set[`IPTC_STACK_BIT] = stack_fault_i;
      trap_set[`IPTC_OSC_BIT]   = osc_failure_i;
   end

   assign trap_event_o = |trap_set;

   // trap register: control bits plain, trap flags sticky
   iptc_sticky #(
      .WIDTH   (16),
      .USED    (`IPTC_TRAP_RW_MASK),
      .RST_VAL (`IPTC_RST_TRAP)
   ) u_trap_flags (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .wr_i      (wr_trap),
      .wr_mask_i (wmask),
      .wr_data_i (wdata),
      .set_i     (trap_set),
      .flags_o   (trap_flags_r)
   );

   // vector select and edge polarity
   always @* begin
      alternate_vector_select_nxt = alternate_vector_select_r;
      edge_polarity_nxt           = edge_polarity_r;
      if (wr_vecedge & sel_i[1]) begin
         alternate_vector_select_nxt = wdata[`IPTC_ALT_VEC_BIT];
      end
      if (wr_vecedge & sel_i[0]) begin
         edge_polarity_nxt = wdata[`IPTC_EDGE_MSB:0];
      end
   end

   // one edge detector per external pin, polarity per pin
   iptc_edge_det #(
      .WIDTH (1)
   ) u_edge0 (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .pin_i     (ext_irq_i[0]),
      .neg_sel_i (edge_polarity_r[0]),
      .edge_o    (ext_edge_o[0])
   );

   iptc_edge_det #(
      .WIDTH (1)
   ) u_edge1 (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .pin_i     (ext_irq_i[1]),
      .neg_sel_i (edge_polarity_r[1]),
      .edge_o    (ext_edge_o[1])
   );

   iptc_edge_det #(
      .WIDTH (1)
   ) u_edge2 (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .pin_i     (ext_irq_i[2]),
      .neg_sel_i (edge_polarity_r[2]),
      .edge_o    (ext_edge_o[2])
   );

   iptc_edge_det #(
      .WIDTH (1)
   ) u_edge3 (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .pin_i     (ext_irq_i[3]),
      .neg_sel_i (edge_polarity_r[3]),
      .edge_o    (ext_edge_o[3])
   );

   iptc_edge_det #(
      .WIDTH (1)
   ) u_edge4 (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .pin_i     (ext_irq_i[4]),
      .neg_sel_i (edge_polarity_r[4]),
      .edge_o    (ext_edge_o[4])
   );

   // request flags: hardware sets, software writes
   assign flag_set = {1'b0, periph_req_i, ext_edge_o[0]};

   iptc_sticky #(
      .WIDTH   (16),
      .USED    (`IPTC_FLAGS0_MASK),
      .RST_VAL (`IPTC_RST_FLAGS0)
   ) u_req_flags (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .wr_i      (wr_flags0),
      .wr_mask_i (wmask),
      .wr_data_i (wdata),
      .set_i     (flag_set),
      .flags_o   (flag_status_zero_r)
   );

   assign request_flags_o = flag_status_zero_r;

   // state registers
   always @(posedge clk_i) begin
      if (rst_i) begin
         priority_low_field_r      <= `IPTC_RST_PRIO_LO;
         priority_upper_bit_r      <= `IPTC_RST_PRIO_UP;
         alternate_vector_select_r <= `IPTC_RST_ALT_VEC;
         edge_polarity_r           <= `IPTC_RST_EDGE;
      end else begin
         priority_low_field_r      <= priority_low_field_nxt;
         priority_upper_bit_r      <= priority_upper_bit_nxt;
         alternate_vector_select_r <= alternate_vector_select_nxt;
         edge_polarity_r           <= edge_polarity_nxt;
      end
   end

   // read mux
   always @* begin
      rd_word = 16'h0000;
      case (adr_i)
         `IPTC_ADR_STATUS: begin
            rd_word[`IPTC_PRIO_LO_MSB:`IPTC_PRIO_LO_LSB] = priority_low_field_r;
         end
         `IPTC_ADR_CORE: begin
            rd_word[`IPTC_PRIO_UP_BIT] = priority_upper_bit_r;
         end
         `IPTC_ADR_TRAP: begin
            rd_word = trap_flags_r;
         end
         `IPTC_ADR_VECEDGE: begin
            rd_word[`IPTC_ALT_VEC_BIT]  = alternate_vector_select_r;
            rd_word[`IPTC_DISABLE_INSTRUCTION_ACTIVE_BIT]     = disable_instruction_active_i;
            rd_word[`IPTC_EDGE_MSB:0]   = edge_polarity_r;
         end
         `IPTC_ADR_FLAGS0: begin
            rd_word = flag_status_zero_r;
         end
         default: begin
            rd_word = 16'h0000;
         end
      endcase
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h00000000;
      end else if (bus_req & ~we_i & ~ack_r) begin
         dat_o <= {16'h0000, rd_word};
      end
   end

endmodule // iptc_interrupt_priority_trap_control

// register with byte-wise software write and sticky hardware set bits
module iptc_sticky #(
   parameter             WIDTH   = 16,
   parameter [WIDTH-1:0] USED    = {WIDTH{1'b1}},
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
   // clock and reset
   input  wire             clk_i,
   input  wire             rst_i,
   // software write
   input  wire             wr_i,
   input  wire [WIDTH-1:0] wr_mask_i,
   input  wire [WIDTH-1:0] wr_data_i,
   // hardware set
   input  wire [WIDTH-1:0] set_i,
   // register contents
   output wire [WIDTH-1:0] flags_o
);

   reg  [WIDTH-1:0] flags_r;
   reg  [WIDTH-1:0] flags_nxt;

   assign flags_o = flags_r;

   // set wins over a simultaneous software clear; unused bits read 0
   always @* begin
      flags_nxt = flags_r;
      if (wr_i) begin
         flags_nxt = (flags_r & ~wr_mask_i) | (wr_data_i & wr_mask_i);
      end
      flags_nxt = (flags_nxt | set_i) & USED;
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         flags_r <= RST_VAL;
      end else begin
         flags_r <= flags_nxt;
      end
   end

endmodule // iptc_sticky

// edge detector with per-bit polarity; a 1 selects the falling edge
module iptc_edge_det #(
   parameter WIDTH = 5
) (
   // clock and reset
   input  wire             clk_i,
   input  wire             rst_i,
   // pin and polarity
   input  wire [WIDTH-1:0] pin_i,
   input  wire [WIDTH-1:0] neg_sel_i,
   // one-cycle edge pulse
   output wire [WIDTH-1:0] edge_o
);

   reg  [WIDTH-1:0] pin_prev_r;

   wire [WIDTH-1:0] rise;
   wire [WIDTH-1:0] fall;

   assign rise   = pin_i & ~pin_prev_r;
   assign fall   = ~pin_i & pin_prev_r;
   assign edge_o = {WIDTH{~rst_i}} & ((neg_sel_i & fall) | (~neg_sel_i & rise));

   // tracks the pin through reset too, so an idle-high pin gives no false edge
   always @(posedge clk_i) begin
      pin_prev_r <= pin_i;
   end

endmodule // iptc_edge_det

// File: iptc_chk_asserts.sv
`timescale 1ns/1ps
module iptc_chk (
   // clock and reset
   input wire        clk_i,
   input wire        rst_i,
   // bus
   input wire        cyc_i,
   input wire        stb_i,
   input wire        we_i,
   input wire [7:0]  adr_i,
   input wire        ack_o,
   // core and sources
   input wire        cpu_level_load_i,
   input wire [3:0]  cpu_level_i,
   input wire        osc_failure_i,
   input wire [14:1] periph_req_i,
   // status
   input wire [3:0]  prio_level_o,
   input wire        user_irq_block_o,
   input wire        nesting_disable_o,
   input wire        trap_event_o,
   input wire [15:0] request_flags_o
);
   default clocking dc @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire flag_wr = cyc_i & stb_i & we_i & ~ack_o & (adr_i == 8'h10);
   AST_BLOCK: assert property (user_irq_block_o == prio_level_o[3])
      else $error("block differs from upper bit");
   AST_LOAD: assert property (cpu_level_load_i |=> prio_level_o == $past(cpu_level_i))
      else $error("core level load lost");
   AST_UP_RO: assert property (!cpu_level_load_i |=> $stable(prio_level_o[3]))
      else $error("upper bit moved");
   AST_NEST: assert property (
      nesting_disable_o && !cpu_level_load_i |=> $stable(prio_level_o[2:0]))
      else $error("low bits moved while locked");
   AST_FLAG15: assert property (!request_flags_o[15])
      else $error("flag bit 15 set");
   AST_DMA1: assert property (periph_req_i[14] |=> request_flags_o[14])
      else $error("dma flag not set");
   AST_HOLD: assert property (
      !flag_wr |=> (request_flags_o & $past(request_flags_o)) == $past(request_flags_o))
      else $error("flag cleared by hardware");
   AST_TRAP: assert property (osc_failure_i |-> trap_event_o)
      else $error("trap event missing");
endmodule // iptc_chk

bind iptc_interrupt_priority_trap_control iptc_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .ack_o(ack_o),
   .cpu_level_load_i(cpu_level_load_i), .cpu_level_i(cpu_level_i),
   .osc_failure_i(osc_failure_i), .periph_req_i(periph_req_i), .prio_level_o(prio_level_o),
   .user_irq_block_o(user_irq_block_o), .nesting_disable_o(nesting_disable_o),
   .trap_event_o(trap_event_o), .request_flags_o(request_flags_o));

// File: iptc_src.sv
`timescale 1ns/1ps
module iptc_src (
   // clock
   input  wire        clk_i,
   // commands
   input  wire [10:0] trap_cmd_i,
   input  wire [14:1] req_cmd_i,
   // source pulses
   output reg  [10:0] trap_o = 11'h000,
   output reg  [14:1] req_o = 14'h0000
);
   // one-cycle requests, registered copies of the commands, cleared when the command drops
   always @(posedge clk_i) begin
      trap_o <= trap_cmd_i;
      req_o <= req_cmd_i;
   end
endmodule // iptc_src

// File: iptc_interrupt_priority_trap_control_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
   $display("mismatch %s exp %h got %h", nm, e, g); end end
module iptc_interrupt_priority_trap_control_bench;
   logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic        ld = 1'b0, disable_instruction_active = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [15:0] wd = 16'h0000;
   logic [3:0]  lv = 4'h0;
   logic [4:0]  ext = 5'h00;
   logic [10:0] tc = 11'h000;
   logic [14:1] rc = 14'h0000;
   logic [31:0] d;
   wire  [31:0] rdat;
   wire         ack, blk, nest, alt;
   wire  [3:0]  prio;
   wire  [10:0] tp;
   wire  [14:1] rq;
   wire  [4:0]  edg;
   int          n_errors = 0;
   int          samples_checked = 0;
   logic [15:0] tmap [0:10] = '{16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h0090,
      16'h0050, 16'h0010, 16'h0020, 16'h0008, 16'h0004, 16'h0002};
   always #4 clk = ~clk;
   iptc_src src (.clk_i(clk), .trap_cmd_i(tc), .req_cmd_i(rc), .trap_o(tp), .req_o(rq));
   iptc_interrupt_priority_trap_control dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'h3), .dat_i({16'h0000, wd}),
      .dat_o(rdat), .ack_o(ack), .cpu_level_load_i(ld), .cpu_level_i(lv),
      .disable_instruction_active_i(disable_instruction_active), .prio_level_o(prio), .user_irq_block_o(blk),
      .nesting_disable_o(nest), .alternate_vector_select_o(alt),
      .acc_a_overflow_i(tp[10]), .acc_b_overflow_i(tp[9]), .acc_a_catastrophic_i(tp[8]),
      .acc_b_catastrophic_i(tp[7]), .bad_shift_i(tp[6]), .divide_zero_i(tp[5]),
      .math_fault_i(tp[4]), .dma_fault_i(tp[3]), .address_fault_i(tp[2]),
      .stack_fault_i(tp[1]), .osc_failure_i(tp[0]), .trap_event_o(), .ext_irq_i(ext),
      .periph_req_i(rq), .ext_edge_o(edg), .request_flags_o());
   task automatic bus(input logic [7:0] a, input logic w, input logic [15:0] v);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wd <= v;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         n_errors++;
         results();
      end
      d = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [15:0] e);
      bus(a, 1'b0, 16'h0000);
      `CHK(nm, {16'h0000, e}, d)
   endtask
   task automatic fire(input logic [10:0] t, input logic [14:1] r);
      tc <= t;
      rc <= r;
      @(posedge clk);
      tc <= 11'h000;
      rc <= 14'h0000;
      repeat (2) @(posedge clk);
   endtask
   task automatic load(input logic [3:0] v);
      ld <= 1'b1;
      lv <= v;
      @(posedge clk);
      ld <= 1'b0;
      @(posedge clk);
   endtask
   task automatic s_prio;
      for (int i = 0; i < 5; i++) rdc("reset", 8'(i * 4), 16'h0000);
      bus(8'h00, 1'b1, 16'hFFE0);
      rdc("status", 8'h00, 16'h00E0);
      bus(8'h04, 1'b1, 16'h0008);
      rdc("core", 8'h04, 16'h0000);
      load(4'h9);
      `CHK("level", 4'h9, prio)
      `CHK("block", 1'b1, blk)
      rdc("core", 8'h04, 16'h0008);
      rdc("status", 8'h00, 16'h0020);
   endtask
   task automatic s_nest;
      bus(8'h08, 1'b1, 16'h8000);
      `CHK("nest", 1'b1, nest)
      bus(8'h00, 1'b1, 16'h0040);
      rdc("status", 8'h00, 16'h0020);
      bus(8'h08, 1'b1, 16'h0000);
      load(4'h7);
      rdc("core", 8'h04, 16'h0000);
      `CHK("block", 1'b0, blk)
   endtask
   task automatic s_traps;
      fire(11'h400, 14'h0000);
      rdc("gated", 8'h08, 16'h0000);
      bus(8'h08, 1'b1, 16'h0700);
      for (int i = 0; i < 11; i++) begin
         fire(11'(1 << (10 - i)), 14'h0000);
         rdc("trap", 8'h08, 16'h0700 | tmap[i]);
         bus(8'h08, 1'b1, 16'h0700);
      end
   endtask
   task automatic s_flags;
      fire(11'h000, 14'h3FFF);
      rdc("flags", 8'h10, 16'h7FFE);
      bus(8'h10, 1'b1, 16'h0000);
      rdc("flags", 8'h10, 16'h0000);
      ext <= 5'h01;
      @(negedge clk);
      `CHK("posedge", 5'h01, edg)
      @(posedge clk);
      rdc("rise", 8'h10, 16'h0001);
      bus(8'h10, 1'b1, 16'h0000);
      bus(8'h0C, 1'b1, 16'h8001);
      `CHK("alt", 1'b1, alt)
      ext <= 5'h00;
      @(negedge clk);
      `CHK("negedge", 5'h01, edg)
      @(posedge clk);
      rdc("fall", 8'h10, 16'h0001);
      bus(8'h10, 1'b1, 16'h0000);
      ext <= 5'h01;
      @(posedge clk);
      rdc("ignored", 8'h10, 16'h0000);
      disable_instruction_active <= 1'b1;
      rdc("vecedge", 8'h0C, 16'hC001);
      rdc("unmapped", 8'h14, 16'h0000);
   endtask
   task automatic results;
      if (n_errors == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      s_prio();
      s_nest();
      s_traps();
      s_flags();
      results();
   end
   initial begin
      repeat (3000) @(posedge clk);
      n_errors++;
      results();
   end
endmodule // iptc_interrupt_priority_trap_control_bench
